// ==== cjx_regs.vh ====
// Constants for the conditional jump, mark and remote execute sequencer
// What this block does
// - Unconditional jump loads the program counter with the second-word address.
// - Jump on overflow branches only if overflow set; always clears overflow.
// - Jump on A non-negative branches when A is zero or positive.
// - Jump on A negative branches when A sign is set, else falls through.
// - A, B and index zero tests branch when that register is all zero.
// - Sense switch tests branch when the selected switch is set.
// - Branch address comes from second word, indirect allowed, never indexed.
// - Jump-and-mark decodes its condition field exactly like the jump group.
// - Unconditional mark stores the counter at the address, resumes at address plus one.
// - Mark on overflow stores and branches only if overflow set; always clears it.
// - Mark variants use all register and switch tests; pass stores and branches.
// - Execute condition is the AND of all tests selected in the field.
// - Execute address is taken from the second instruction word.
// - Unconditional execute runs the remote instruction, then continues in sequence.
// - Execute on overflow runs remote only if set; always clears overflow.
// - Execute variants run remote on pass and always continue in sequence.
// - Extended group takes the second word as address; bit 15 selects indirect only in modes 4 to 7.
// - Extended mode 0 is immediate; mode 1 adds counter plus one.
// - Extended mode 2 adds index, mode 3 adds B, mode 4 direct or indirect.
// - Condition field bit 0 selects the overflow flag test.
`ifndef CJX_REGS_VH
`define CJX_REGS_VH

// Word and address widths
`define CJX_WORD_W 16
`define CJX_ADDR_W 15
`define CJX_COND_W 9
`define CJX_INDIRECT_BIT 15

// Instruction groups on the group port
`define CJX_GRP_JUMP 2'h0
`define CJX_GRP_MARK 2'h1
`define CJX_GRP_EXEC 2'h2
`define CJX_GRP_EXT 2'h3

// Condition field bit positions
`define CJX_C_OVF 0
`define CJX_C_A_NONNEG 1
`define CJX_C_A_NEG 2
`define CJX_C_A_ZERO 3
`define CJX_C_B_ZERO 4
`define CJX_C_X_ZERO 5
`define CJX_C_SENSE1 6
`define CJX_C_SENSE2 7
`define CJX_C_SENSE3 8

// Extended addressing modes
`define CJX_M_IMM 3'h0
`define CJX_M_REL 3'h1
`define CJX_M_IDX_X 3'h2
`define CJX_M_IDX_B 3'h3
`define CJX_M_DIRIND 3'h4

// Reset values
`define CJX_RST_ADDR 15'h0000
`define CJX_RST_WORD 16'h0000

`endif

// ==== cjx_cond.v ====
// Nine-way condition evaluator, AND of every selected test
module cjx_cond (
  // Condition field and snapshot of the machine state
  input wire [8:0] cond_field,
  input wire ovf,
  input wire [15:0] a_val,
  input wire [15:0] b_val,
  input wire [15:0] x_val,
  input wire [2:0] sense,
  // Result
  output wire pass
);

`include "cjx_regs.vh"

wire [8:0] test;
wire [8:0] bit_ok;

// Raw test per condition bit
assign test[`CJX_C_OVF] = ovf;
assign test[`CJX_C_A_NONNEG] = ~a_val[`CJX_WORD_W-1];
assign test[`CJX_C_A_NEG] = a_val[`CJX_WORD_W-1];
assign test[`CJX_C_A_ZERO] = (a_val == `CJX_RST_WORD);
assign test[`CJX_C_B_ZERO] = (b_val == `CJX_RST_WORD);
assign test[`CJX_C_X_ZERO] = (x_val == `CJX_RST_WORD);
assign test[`CJX_C_SENSE1] = sense[0];
assign test[`CJX_C_SENSE2] = sense[1];
assign test[`CJX_C_SENSE3] = sense[2];

// Unselected bits never block; selected bits must hold
genvar i;
generate
  for (i = 0; i < `CJX_COND_W; i = i + 1)
  begin : g_bit
    assign bit_ok[i] = ~cond_field[i] | test[i];
  end
endgenerate

// All ones field combine by AND; empty field always passes
assign pass = &bit_ok;

endmodule

// ==== cjx_unit.v ====
// Sequencer for conditional jump, jump-and-mark, remote execute and extended addressing
module cjx_unit (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Instruction request
  input wire START,
  input wire [1:0] OP_GROUP,
  input wire [8:0] COND_FIELD,
  input wire [2:0] EXT_MODE,
  input wire [14:0] PC_IN,
  // Machine state before the instruction
  input wire [15:0] A_REG,
  input wire [15:0] B_REG,
  input wire [15:0] X_REG,
  input wire OVERFLOW_FLAG,
  input wire [2:0] SENSE_SW,
  // Memory port
  output reg MEM_REQ,
  output reg MEM_WE,
  output reg [14:0] MEM_ADDR,
  output reg [15:0] MEM_WDATA,
  input wire [15:0] MEM_RDATA,
  input wire MEM_ACK,
  // Results to the processor
  output reg BUSY,
  output reg DONE,
  output reg [14:0] PC_OUT,
  output reg OVF_CLR,
  output reg EXEC_REQ,
  output reg [14:0] EXEC_ADDR,
  output reg EA_VALID,
  output reg EA_IMM,
  output reg [15:0] EA_OUT
);

`include "cjx_regs.vh"

// Sequencer states
localparam ST_IDLE = 3'h0;
localparam ST_FETCH = 3'h1;
localparam ST_INDIR = 3'h2;
localparam ST_ACT = 3'h3;
localparam ST_MARK = 3'h4;

localparam [14:0] ADDR_ONE = 15'h0001;
localparam [14:0] ADDR_TWO = 15'h0002;
localparam [15:0] WORD_ONE = 16'h0001;

// Latched instruction and machine snapshot
reg [2:0] state_q;
reg [2:0] state_d;
reg [1:0] grp_q;
reg [8:0] cond_q;
reg [2:0] mode_q;
reg [14:0] pc_q;
reg [15:0] a_q;
reg [15:0] b_q;
reg [15:0] x_q;
reg ovf_q;
reg [2:0] sense_q;
reg [14:0] ea_q;
reg [14:0] ea_d;

// Registered outputs, next values
reg mem_req_d;
reg mem_we_d;
reg [14:0] mem_addr_d;
reg [15:0] mem_wdata_d;
reg done_d;
reg [14:0] pc_out_d;
reg ovf_clr_d;
reg exec_req_d;
reg [14:0] exec_addr_d;
reg ea_valid_d;
reg ea_imm_d;
reg [15:0] ea_out_d;

wire cond_pass;
wire [14:0] seq_pc;
wire [14:0] second_addr;
wire [15:0] rel_sum;
wire [15:0] x_sum;
wire [15:0] b_sum;
wire is_ext;
wire clears_ovf;

// Condition decode shared by jump, mark and execute groups
cjx_cond u_cond (
  .cond_field(cond_q),
  .ovf(ovf_q),
  .a_val(a_q),
  .b_val(b_q),
  .x_val(x_q),
  .sense(sense_q),
  .pass(cond_pass)
);

// Address arithmetic
assign seq_pc = pc_q + ADDR_TWO;
assign second_addr = pc_q + ADDR_ONE;
assign rel_sum = MEM_RDATA + {1'b0, second_addr};
assign x_sum = MEM_RDATA + x_q;
assign b_sum = MEM_RDATA + b_q;
assign is_ext = (grp_q == `CJX_GRP_EXT);
assign clears_ovf = ~is_ext & cond_q[`CJX_C_OVF];

// Snapshot at start so tests see pre-instruction values
always @(posedge CLK)
begin
  if (RST)
  begin
    grp_q <= `CJX_GRP_JUMP;
    cond_q <= 9'h000;
    mode_q <= `CJX_M_IMM;
    pc_q <= `CJX_RST_ADDR;
    a_q <= `CJX_RST_WORD;
    b_q <= `CJX_RST_WORD;
    x_q <= `CJX_RST_WORD;
    ovf_q <= 1'b0;
    sense_q <= 3'h0;
  end
  else if (state_q == ST_IDLE && START)
  begin
    grp_q <= OP_GROUP;
    cond_q <= COND_FIELD;
    mode_q <= EXT_MODE;
    pc_q <= PC_IN;
    a_q <= A_REG;
    b_q <= B_REG;
    x_q <= X_REG;
    ovf_q <= OVERFLOW_FLAG;
    sense_q <= SENSE_SW;
  end
end

// Next state and output values
always @*
begin
  state_d = state_q;
  ea_d = ea_q;
  mem_req_d = MEM_REQ;
  mem_we_d = MEM_WE;
  mem_addr_d = MEM_ADDR;
  mem_wdata_d = MEM_WDATA;
  done_d = 1'b0;
  pc_out_d = PC_OUT;
  ovf_clr_d = 1'b0;
  exec_req_d = 1'b0;
  exec_addr_d = EXEC_ADDR;
  ea_valid_d = 1'b0;
  ea_imm_d = EA_IMM;
  ea_out_d = EA_OUT;
  case (state_q)
    ST_IDLE:
    begin
      if (START)
      begin
        // Second word sits right after the instruction word
        mem_req_d = 1'b1;
        mem_we_d = 1'b0;
        mem_addr_d = PC_IN + ADDR_ONE;
        state_d = ST_FETCH;
      end
    end
    ST_FETCH:
    begin
      if (MEM_ACK)
      begin
        mem_req_d = 1'b0;
        if (is_ext)
        begin
          case (mode_q)
            `CJX_M_IMM:
            begin
              // Second word is the operand itself
              ea_out_d = MEM_RDATA;
              ea_imm_d = 1'b1;
              ea_valid_d = 1'b1;
              done_d = 1'b1;
              pc_out_d = seq_pc;
              state_d = ST_IDLE;
            end
            `CJX_M_REL:
            begin
              ea_d = rel_sum[14:0];
              state_d = ST_ACT;
            end
            `CJX_M_IDX_X:
            begin
              ea_d = x_sum[14:0];
              state_d = ST_ACT;
            end
            `CJX_M_IDX_B:
            begin
              ea_d = b_sum[14:0];
              state_d = ST_ACT;
            end
            default:
            begin
              // Direct or indirect by the top bit of the second word
              ea_d = MEM_RDATA[14:0];
              if (MEM_RDATA[`CJX_INDIRECT_BIT])
              begin
                mem_req_d = 1'b1;
                mem_addr_d = MEM_RDATA[14:0];
                state_d = ST_INDIR;
              end
              else
              begin
                state_d = ST_ACT;
              end
            end
          endcase
        end
        else if (!cond_pass)
        begin
          // Test failed: skip both words
          done_d = 1'b1;
          pc_out_d = seq_pc;
          ovf_clr_d = clears_ovf;
          state_d = ST_IDLE;
        end
        else if (MEM_RDATA[`CJX_INDIRECT_BIT])
        begin
          // Indirect branch address, no indexing
          mem_req_d = 1'b1;
          mem_addr_d = MEM_RDATA[14:0];
          state_d = ST_INDIR;
        end
        else
        begin
          ea_d = MEM_RDATA[14:0];
          state_d = ST_ACT;
        end
      end
    end
    ST_INDIR:
    begin
      if (MEM_ACK)
      begin
        // Follow the chain until a direct word appears
        if (MEM_RDATA[`CJX_INDIRECT_BIT])
        begin
          mem_addr_d = MEM_RDATA[14:0];
        end
        else
        begin
          mem_req_d = 1'b0;
          ea_d = MEM_RDATA[14:0];
          state_d = ST_ACT;
        end
      end
    end
    ST_ACT:
    begin
      case (grp_q)
        `CJX_GRP_JUMP:
        begin
          done_d = 1'b1;
          pc_out_d = ea_q;
          ovf_clr_d = clears_ovf;
          state_d = ST_IDLE;
        end
        `CJX_GRP_MARK:
        begin
          // Return link written at the jump address
          mem_req_d = 1'b1;
          mem_we_d = 1'b1;
          mem_addr_d = ea_q;
          mem_wdata_d = {1'b0, seq_pc};
          state_d = ST_MARK;
        end
        `CJX_GRP_EXEC:
        begin
          // Processor runs one instruction there, then resumes here
          exec_req_d = 1'b1;
          exec_addr_d = ea_q;
          done_d = 1'b1;
          pc_out_d = seq_pc;
          ovf_clr_d = clears_ovf;
          state_d = ST_IDLE;
        end
        default:
        begin
          ea_out_d = {1'b0, ea_q};
          ea_imm_d = 1'b0;
          ea_valid_d = 1'b1;
          done_d = 1'b1;
          pc_out_d = seq_pc;
          state_d = ST_IDLE;
        end
      endcase
    end
    ST_MARK:
    begin
      if (MEM_ACK)
      begin
        mem_req_d = 1'b0;
        mem_we_d = 1'b0;
        done_d = 1'b1;
        pc_out_d = ea_q + ADDR_ONE;
        ovf_clr_d = clears_ovf;
        state_d = ST_IDLE;
      end
    end
    default:
    begin
      mem_req_d = 1'b0;
      mem_we_d = 1'b0;
      state_d = ST_IDLE;
    end
  endcase
end

// State and output flip-flops
always @(posedge CLK)
begin
  if (RST)
  begin
    state_q <= ST_IDLE;
    ea_q <= `CJX_RST_ADDR;
    MEM_REQ <= 1'b0;
    MEM_WE <= 1'b0;
    MEM_ADDR <= `CJX_RST_ADDR;
    MEM_WDATA <= `CJX_RST_WORD;
    BUSY <= 1'b0;
    DONE <= 1'b0;
    PC_OUT <= `CJX_RST_ADDR;
    OVF_CLR <= 1'b0;
    EXEC_REQ <= 1'b0;
    EXEC_ADDR <= `CJX_RST_ADDR;
    EA_VALID <= 1'b0;
    EA_IMM <= 1'b0;
    EA_OUT <= `CJX_RST_WORD;
  end
  else
  begin
    state_q <= state_d;
    ea_q <= ea_d;
    MEM_REQ <= mem_req_d;
    MEM_WE <= mem_we_d;
    MEM_ADDR <= mem_addr_d;
    MEM_WDATA <= mem_wdata_d;
    BUSY <= (state_d != ST_IDLE);
    DONE <= done_d;
    PC_OUT <= pc_out_d;
    OVF_CLR <= ovf_clr_d;
    EXEC_REQ <= exec_req_d;
    EXEC_ADDR <= exec_addr_d;
    EA_VALID <= ea_valid_d;
    EA_IMM <= ea_imm_d;
    EA_OUT <= ea_out_d;
  end
end

endmodule

// ==== cjx_unit_asserts.sv ====
// Port checks for the jump, mark and execute sequencer
module cjx_unit_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Request
  input wire logic START,
  input wire logic [14:0] PC_IN,
  // Memory
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [14:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  // Results
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [14:0] PC_OUT,
  input wire logic OVF_CLR,
  input wire logic EXEC_REQ,
  input wire logic EA_VALID,
  input wire logic EA_IMM,
  input wire logic [15:0] EA_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] pc_q;
  // Address of the accepted instruction
  always @(posedge CLK)
  begin
    if (RST)
      pc_q <= 15'h0000;
    else if (START && !BUSY)
      pc_q <= PC_IN;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  done_pulse_a: assert property (DONE |-> !BUSY ##1 !DONE) else $error("done not a pulse");
  start_busy_a: assert property (START && !BUSY |=> BUSY) else $error("start lost");
  first_read_a: assert property ($rose(BUSY) |-> MEM_REQ && !MEM_WE && MEM_ADDR == pc_q + 15'h1)
    else $error("bad first read");
  req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WDATA))
    else $error("request moved");
  link_data_a: assert property (MEM_REQ && MEM_WE |-> MEM_WDATA == {1'b0, pc_q + 15'h2})
    else $error("bad link word");
  link_resume_a: assert property (MEM_WE && MEM_ACK |=> DONE && PC_OUT == $past(MEM_ADDR) + 15'h1)
    else $error("bad resume");
  side_pulse_a: assert property (OVF_CLR || EXEC_REQ || EA_VALID |-> DONE) else $error("stray pulse");
  exec_seq_a: assert property (EXEC_REQ || EA_VALID |-> PC_OUT == pc_q + 15'h2)
    else $error("not in sequence");
  ea_addr_a: assert property (EA_VALID && !EA_IMM |-> !EA_OUT[15]) else $error("bad address");
  cover property (EXEC_REQ);
  cover property (MEM_WE && MEM_ACK);
  cover property (EA_VALID && EA_IMM);
endmodule

// ==== cjx_mem.sv ====
// Word memory with a settable answer delay
module cjx_mem (
  // Requests
  input wire logic clk,
  input wire logic req,
  input wire logic we,
  input wire logic [14:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] lat,
  // Answer
  output logic [15:0] rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] m [0:255];
  logic [1:0] cnt = 2'h0;
  initial rdata = 16'h0000;
  initial ack = 1'b0;
  // Answer after lat waits; data toggles between answers
  always @(posedge clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    cnt <= 2'h0;
    if (req && !ack && cnt != lat)
      cnt <= cnt + 2'h1;
    if (req && !ack && cnt == lat)
    begin
      ack <= 1'b1;
      rdata <= m[addr[7:0]];
      if (we)
        m[addr[7:0]] <= wdata;
    end
  end
endmodule

// ==== cjx_unit_tb.sv ====
// Directed bench for the jump, mark and execute sequencer
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t bad %h", $time, g); end end
module cjx_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, ovf = 1'b0, so;
  logic [1:0] grp = 2'h0, lat = 2'h0;
  logic [8:0] cond = 9'h000;
  logic [2:0] mode = 3'h0, sw = 3'h0, ss;
  logic [15:0] av = 16'h0000, bv = 16'h0000, xv = 16'h0000, sa, sb, sx;
  logic [14:0] epc, pcv = 15'h0010;
  wire req, we, ack, busy, done, oclr, xreq, eav, eimm;
  wire [14:0] ma, pco, xad;
  wire [15:0] wd, rd, eao;
  integer err_count = 0, num_checks = 0, cyc = 0, g, k, p, n;
  cjx_unit dut (.CLK(clk), .RST(rst), .START(start), .OP_GROUP(grp), .COND_FIELD(cond), .EXT_MODE(mode),
    .PC_IN(pcv), .A_REG(av), .B_REG(bv), .X_REG(xv), .OVERFLOW_FLAG(ovf), .SENSE_SW(sw), .MEM_REQ(req),
    .MEM_WE(we), .MEM_ADDR(ma), .MEM_WDATA(wd), .MEM_RDATA(rd), .MEM_ACK(ack), .BUSY(busy), .DONE(done),
    .PC_OUT(pco), .OVF_CLR(oclr), .EXEC_REQ(xreq), .EXEC_ADDR(xad), .EA_VALID(eav), .EA_IMM(eimm), .EA_OUT(eao));
  cjx_mem mem (.clk(clk), .req(req), .we(we), .addr(ma), .wdata(wd), .lat(lat), .rdata(rd), .ack(ack));
  always #10 clk = ~clk;
  task summarize;
  begin
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Cycle ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      summarize();
    end
  end
  // One instruction; memory delay steps each call
  task run(input [1:0] g_i, input [8:0] c_i, input [2:0] m_i, input [15:0] a_i, b_i, x_i, input o_i, input [2:0] s_i);
  begin
    @(posedge clk);
    grp <= g_i;
    cond <= c_i;
    mode <= m_i;
    av <= a_i;
    bv <= b_i;
    xv <= x_i;
    ovf <= o_i;
    sw <= s_i;
    lat <= lat + 2'h1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    `CHK(done, 1'b1)
  end
  endtask
  // Main sequence; second word lies at 11
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Each single test, pass and fail, all three groups
    for (g = 0; g < 3; g++)
      for (k = 0; k < 9; k++)
        for (p = 0; p < 2; p++)
        begin
          sa = (k == 1) ? (p ? 16'h7fff : 16'h8000) : (k == 2) ? {p[0], 15'h0000} : (k == 3) ? {~p[0], 15'h0} : 16'h1;
          sb = (k == 4) ? {~p[0], 15'h0000} : 16'h0001;
          sx = (k == 5) ? {14'h0, ~p[0], 1'b0} : 16'h0001;
          so = (k == 0) ? p[0] : 1'b1;
          ss = (k > 5) ? (p ? 3'h1 << (k - 6) : ~(3'h1 << (k - 6))) : 3'h0;
          mem.m[8'h11] = 16'h0040;
          mem.m[8'h40] = 16'h0000;
          run(g[1:0], 9'h001 << k, 3'h0, sa, sb, sx, so, ss[2:0]);
          epc = (p == 0 || g == 2) ? 15'h0012 : (g == 0) ? 15'h0040 : 15'h0041;
          `CHK(pco, epc)
          `CHK(oclr, k == 0)
          `CHK(xreq, g == 2 && p == 1)
          `CHK(mem.m[8'h40], (g == 1 && p == 1) ? 16'h0012 : 16'h0000)
          if (xreq === 1'b1) `CHK(xad, 15'h0040)
        end
    // Unconditional through a two-level pointer chain
    mem.m[8'h11] = 16'h8020;
    mem.m[8'h20] = 16'h8030;
    mem.m[8'h30] = 16'h0050;
    for (g = 0; g < 3; g++)
    begin
      run(g[1:0], 9'h000, 3'h0, 16'h8000, 16'h0001, 16'h0001, 1'b1, 3'h0);
      `CHK(pco, g == 0 ? 15'h0050 : g == 1 ? 15'h0051 : 15'h0012)
    end
    `CHK(xad, 15'h0050)
    `CHK(mem.m[8'h50], 16'h0012)
    // Several tests together; one failing stops the act
    run(2'h2, 9'h1f9, 3'h0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 3'h7);
    `CHK(xreq, 1'b1)
    run(2'h2, 9'h1f9, 3'h0, 16'h0000, 16'h0000, 16'h0000, 1'b1, 3'h6);
    `CHK({xreq, oclr}, 2'h1)
    // Every extended mode; overflow never cleared here
    mem.m[8'h11] = 16'h0030;
    for (k = 0; k < 8; k++)
    begin
      run(2'h3, 9'h001, k[2:0], 16'h0000, 16'h0007, 16'h0005, 1'b1, 3'h0);
      `CHK({eav, eimm, oclr, pco}, {2'h2 | (k == 0), 16'h0012})
      `CHK(eao, k == 1 ? 16'h0041 : k == 2 ? 16'h0035 : k == 3 ? 16'h0037 : 16'h0030)
    end
    mem.m[8'h11] = 16'h8020;
    run(2'h3, 9'h000, 3'h4, 16'h0000, 16'h0000, 16'h0000, 1'b0, 3'h0);
    `CHK(eao, 16'h0050)
    // Another instruction address: relative operand and mark link
    @(posedge clk);
    pcv <= 15'h0020;
    mem.m[8'h21] = 16'h0005;
    run(2'h3, 9'h000, 3'h1, 16'h0000, 16'h0000, 16'h0000, 1'b0, 3'h0);
    `CHK({eao, pco}, {16'h0026, 15'h0022})
    mem.m[8'h21] = 16'h0060;
    run(2'h1, 9'h000, 3'h0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 3'h0);
    `CHK(pco, 15'h0061)
    `CHK(mem.m[8'h60], 16'h0022)
    summarize();
  end
endmodule
bind cjx_unit cjx_unit_asserts chk (.CLK(CLK), .RST(RST), .START(START), .PC_IN(PC_IN), .MEM_REQ(MEM_REQ),
  .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .BUSY(BUSY), .DONE(DONE),
  .PC_OUT(PC_OUT), .OVF_CLR(OVF_CLR), .EXEC_REQ(EXEC_REQ), .EA_VALID(EA_VALID), .EA_IMM(EA_IMM), .EA_OUT(EA_OUT));
